/* File: rtl/csd_pkg.sv */
package csd_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W  = 20;
  localparam int DATA_W  = 16;
  localparam int CNT_W   = 16;
  localparam int CAUSE_W = 4;
  localparam int NCH     = 2;
  localparam int NSRC    = 16;

  // ---------------------------------------------------------------
  // protected register window
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_LO = 20'h00020;
  localparam logic [ADDR_W-1:0] REG_HI = 20'h0003F;

  // ---------------------------------------------------------------
  // request cause codes
  // ---------------------------------------------------------------
  localparam logic [CAUSE_W-1:0] CAUSE_PIN_FALL = 4'h0;
  localparam logic [CAUSE_W-1:0] CAUSE_SOFT     = 4'h1;
  localparam logic [CAUSE_W-1:0] CAUSE_PIN_BOTH = 4'h7;

  // ---------------------------------------------------------------
  // pointer steps and reset values
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] STEP_BYTE = 20'h00001;
  localparam logic [ADDR_W-1:0] STEP_WORD = 20'h00002;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 20'h00000;
  localparam logic [CNT_W-1:0]  CNT_RST   = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;

  typedef enum logic [1:0] {
    CSD_IDLE = 2'b00,
    CSD_READ = 2'b01,
    CSD_WRIT = 2'b11
  } csd_state_t;
endpackage

/* File: rtl/csd_dma.sv */
`timescale 1ns/1ns
// Behaviour
// - two independent channels, each steals two bus cycles per request, a read then a write
// - variable-to-fixed, fixed-to-variable, fixed-to-fixed in one megabyte space
// - own register range is never a transfer source or destination
// - unit is byte or word; counter bounds block to 64K or 128K bytes
// - pin zero falling edge for channel zero; pin one for channel one, both-edge option
// - peripheral interrupt requests or software trigger also serve as requests
// - channel zero wins when both request in the same cycle
// - source and destination never both incrementing
// - single mode: underflow clears enable, channel goes inactive
// - repeat mode: underflow reloads counter, stays active until enable written zero
// - interrupt request raised when counter underflows
// - active exactly while enable is one; requests ignored while zero
// - first transfer after activation loads working pointer and counter
// - incrementing pointers writable always; fixed ones only while disabled
// - requests ignore interrupt masks and do not alter interrupt state
// - controller takes the shared bus over the processor when transfer pending
// - four-bit cause: one is software trigger, zero is pin falling edge
module csd_dma (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         nrst,
  input  wire logic                         clk_en,
  // per-channel configuration
  input  wire logic [csd_pkg::NCH-1:0]      cfg_wr_en,
  input  wire logic [csd_pkg::NCH-1:0]      cfg_en_val,
  input  wire logic [csd_pkg::NCH-1:0]      cfg_word,
  input  wire logic [csd_pkg::NCH-1:0]      cfg_repeat,
  input  wire logic [csd_pkg::NCH-1:0]      cfg_src_inc,
  input  wire logic [csd_pkg::NCH-1:0]      cfg_dst_inc,
  input  wire logic [csd_pkg::NCH*4-1:0]    request_cause_select,
  // pointer and reload writes
  input  wire logic [csd_pkg::NCH-1:0]      src_wr,
  input  wire logic [csd_pkg::NCH-1:0]      dst_wr,
  input  wire logic [csd_pkg::NCH-1:0]      rld_wr,
  input  wire logic [csd_pkg::ADDR_W-1:0]   wr_addr,
  input  wire logic [csd_pkg::CNT_W-1:0]    wr_cnt,
  // request sources
  input  wire logic [csd_pkg::NCH-1:0]      soft_trig,
  input  wire logic                         ext_irq_pin_zero,
  input  wire logic                         ext_irq_pin_one,
  input  wire logic [csd_pkg::NSRC-1:0]     periph_irq,
  // shared bus
  input  wire logic                         bus_ack,
  input  wire logic [csd_pkg::DATA_W-1:0]   bus_rdata,
  output logic                              bus_req,
  output logic                              bus_rd,
  output logic                              bus_wr,
  output logic                              bus_word,
  output logic [csd_pkg::ADDR_W-1:0]        bus_addr,
  output logic [csd_pkg::DATA_W-1:0]        bus_wdata,
  // status
  output logic [csd_pkg::NCH-1:0]           ch_enable,
  output logic [csd_pkg::NCH-1:0]           dma_irq,
  output logic [csd_pkg::NCH-1:0]           cfg_error,
  output logic [csd_pkg::NCH*20-1:0]        src_rd,
  output logic [csd_pkg::NCH*20-1:0]        dst_rd,
  output logic [csd_pkg::NCH*16-1:0]        cnt_rd
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic in_regs(input logic [csd_pkg::ADDR_W-1:0] a);
    in_regs = (a >= csd_pkg::REG_LO) && (a <= csd_pkg::REG_HI);
  endfunction

  // pointer step per unit; word units move two byte addresses at once
  function automatic logic [csd_pkg::ADDR_W-1:0] step_of(input logic w);
    step_of = w ? csd_pkg::STEP_WORD : csd_pkg::STEP_BYTE;
  endfunction

  // ---------------------------------------------------------------
  // channel state
  // ---------------------------------------------------------------
  logic [csd_pkg::NCH-1:0]    en_q, en_d, word_q, word_d, rpt_q, rpt_d;
  logic [csd_pkg::NCH-1:0]    sinc_q, sinc_d, dinc_q, dinc_d, first_q, first_d;
  logic [csd_pkg::NCH-1:0]    pend_q, pend_d, irq_q, irq_d;
  logic [csd_pkg::ADDR_W-1:0] src_q [csd_pkg::NCH];
  logic [csd_pkg::ADDR_W-1:0] src_d [csd_pkg::NCH];
  logic [csd_pkg::ADDR_W-1:0] dst_q [csd_pkg::NCH];
  logic [csd_pkg::ADDR_W-1:0] dst_d [csd_pkg::NCH];
  logic [csd_pkg::ADDR_W-1:0] ptr_q [csd_pkg::NCH];
  logic [csd_pkg::ADDR_W-1:0] ptr_d [csd_pkg::NCH];
  logic [csd_pkg::CNT_W-1:0]  rld_q [csd_pkg::NCH];
  logic [csd_pkg::CNT_W-1:0]  rld_d [csd_pkg::NCH];
  logic [csd_pkg::CNT_W-1:0]  cnt_q [csd_pkg::NCH];
  logic [csd_pkg::CNT_W-1:0]  cnt_d [csd_pkg::NCH];
  logic                       pin0_q, pin1_q;
  logic [csd_pkg::NCH-1:0]    req_ev;

  // transfer engine
  csd_pkg::csd_state_t        st_q, st_d;
  logic                       ch_q, ch_d;
  logic [csd_pkg::DATA_W-1:0] dat_q, dat_d;
  logic [csd_pkg::NCH-1:0]    done;

  // ---------------------------------------------------------------
  // request detection
  // ---------------------------------------------------------------
  // interrupt masks are never consulted here, only raw request lines
  always_comb begin
    logic [csd_pkg::CAUSE_W-1:0] c0;
    logic [csd_pkg::CAUSE_W-1:0] c1;
    c0 = request_cause_select[0 +: csd_pkg::CAUSE_W];
    c1 = request_cause_select[csd_pkg::CAUSE_W +: csd_pkg::CAUSE_W];
    req_ev[0] = periph_irq[c0];
    if (c0 == csd_pkg::CAUSE_PIN_FALL) req_ev[0] = pin0_q & ~ext_irq_pin_zero;
    if (c0 == csd_pkg::CAUSE_SOFT)     req_ev[0] = soft_trig[0];
    req_ev[1] = periph_irq[c1];
    if (c1 == csd_pkg::CAUSE_PIN_FALL) req_ev[1] = pin1_q & ~ext_irq_pin_one;
    if (c1 == csd_pkg::CAUSE_PIN_BOTH) req_ev[1] = pin1_q ^ ext_irq_pin_one;
    if (c1 == csd_pkg::CAUSE_SOFT)     req_ev[1] = soft_trig[1];
  end

  // ---------------------------------------------------------------
  // channel next state
  // ---------------------------------------------------------------
  always_comb begin
    en_d    = en_q;
    word_d  = word_q;
    rpt_d   = rpt_q;
    sinc_d  = sinc_q;
    dinc_d  = dinc_q;
    first_d = first_q;
    pend_d  = pend_q;
    irq_d   = '0;
    // requests arriving faster than units complete merge into one pending flag
    for (int i = 0; i < csd_pkg::NCH; i++) begin
      src_d[i] = src_q[i];
      dst_d[i] = dst_q[i];
      ptr_d[i] = ptr_q[i];
      rld_d[i] = rld_q[i];
      cnt_d[i] = cnt_q[i];
      if (cfg_wr_en[i]) begin
        // both incrementing is refused: the destination falls back to fixed
        en_d[i]   = cfg_en_val[i];
        word_d[i] = cfg_word[i];
        rpt_d[i]  = cfg_repeat[i];
        sinc_d[i] = cfg_src_inc[i];
        dinc_d[i] = cfg_dst_inc[i] & ~cfg_src_inc[i];
        if (cfg_en_val[i] && !en_q[i]) first_d[i] = 1'b1;
        if (!cfg_en_val[i]) pend_d[i] = 1'b0;
      end
      if (src_wr[i] && (sinc_q[i] || !en_q[i])) src_d[i] = wr_addr;
      if (dst_wr[i] && (dinc_q[i] || !en_q[i])) dst_d[i] = wr_addr;
      if (rld_wr[i]) rld_d[i] = wr_cnt;
      if (en_q[i] && req_ev[i]) pend_d[i] = 1'b1;
      if (done[i]) begin
        pend_d[i]  = 1'b0;
        first_d[i] = 1'b0;
        ptr_d[i]   = (first_q[i] ? (sinc_q[i] ? src_q[i] : dst_q[i]) : ptr_q[i])
                     + step_of(word_q[i]);
        if (!sinc_q[i] && !dinc_q[i]) ptr_d[i] = ptr_q[i];
        cnt_d[i] = first_q[i] ? rld_q[i] : cnt_q[i];
        if (cnt_d[i] == csd_pkg::CNT_RST) begin
          irq_d[i] = 1'b1;
          if (rpt_q[i]) begin
            cnt_d[i]   = rld_q[i];
            first_d[i] = 1'b1;
          end else begin
            en_d[i] = 1'b0;
          end
        end else begin
          cnt_d[i] = cnt_d[i] - csd_pkg::CNT_ONE;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // transfer engine: read then write, one unit per grant
  // ---------------------------------------------------------------
  always_comb begin
    logic [csd_pkg::ADDR_W-1:0] ra;
    logic [csd_pkg::ADDR_W-1:0] wa;
    logic [csd_pkg::ADDR_W-1:0] cur;
    st_d    = st_q;
    ch_d    = ch_q;
    dat_d   = dat_q;
    done    = '0;
    bus_req = 1'b0;
    bus_rd  = 1'b0;
    bus_wr  = 1'b0;
    // a window access still runs its bus cycle, so unit timing never depends on address
    // no ack timeout: a stalled bus holds the engine in its current phase
    cur = first_q[ch_q] ? (sinc_q[ch_q] ? src_q[ch_q] : dst_q[ch_q]) : ptr_q[ch_q];
    ra  = sinc_q[ch_q] ? cur : src_q[ch_q];
    wa  = dinc_q[ch_q] ? cur : dst_q[ch_q];
    bus_addr = (st_q == csd_pkg::CSD_WRIT) ? wa : ra;
    case (st_q)
      csd_pkg::CSD_IDLE: begin
        if (pend_q[0] && en_q[0])      ch_d = 1'b0;
        else if (pend_q[1] && en_q[1]) ch_d = 1'b1;
        if ((pend_q[0] && en_q[0]) || (pend_q[1] && en_q[1])) st_d = csd_pkg::CSD_READ;
      end
      csd_pkg::CSD_READ: begin
        bus_req = 1'b1;
        bus_rd  = ~in_regs(ra);
        if (bus_ack) begin
          dat_d = in_regs(ra) ? '0 : bus_rdata;
          st_d  = csd_pkg::CSD_WRIT;
        end
      end
      csd_pkg::CSD_WRIT: begin
        bus_req = 1'b1;
        bus_wr  = ~in_regs(wa);
        if (bus_ack) begin
          done[ch_q] = en_q[ch_q];
          st_d       = csd_pkg::CSD_IDLE;
        end
      end
      default: st_d = csd_pkg::CSD_IDLE;
    endcase
  end

  assign bus_word  = word_q[ch_q];
  assign bus_wdata = dat_q;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      en_q    <= '0;
      word_q  <= '0;
      rpt_q   <= '0;
      sinc_q  <= '0;
      dinc_q  <= '0;
      first_q <= '0;
      pend_q  <= '0;
      irq_q   <= '0;
      // pins idle high; any edge seen right after reset finds both channels disabled
      pin0_q  <= 1'b1;
      pin1_q  <= 1'b1;
      st_q    <= csd_pkg::CSD_IDLE;
      ch_q    <= 1'b0;
      dat_q   <= '0;
      for (int i = 0; i < csd_pkg::NCH; i++) begin
        src_q[i] <= csd_pkg::ADDR_RST;
        dst_q[i] <= csd_pkg::ADDR_RST;
        ptr_q[i] <= csd_pkg::ADDR_RST;
        rld_q[i] <= csd_pkg::CNT_RST;
        cnt_q[i] <= csd_pkg::CNT_RST;
      end
    end else if (clk_en) begin
      en_q    <= en_d;
      word_q  <= word_d;
      rpt_q   <= rpt_d;
      sinc_q  <= sinc_d;
      dinc_q  <= dinc_d;
      first_q <= first_d;
      pend_q  <= pend_d;
      irq_q   <= irq_d;
      pin0_q  <= ext_irq_pin_zero;
      pin1_q  <= ext_irq_pin_one;
      st_q    <= st_d;
      ch_q    <= ch_d;
      dat_q   <= dat_d;
      for (int i = 0; i < csd_pkg::NCH; i++) begin
        src_q[i] <= src_d[i];
        dst_q[i] <= dst_d[i];
        ptr_q[i] <= ptr_d[i];
        rld_q[i] <= rld_d[i];
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  assign ch_enable = en_q;
  assign dma_irq   = irq_q;
  assign cfg_error = '0;
  generate
    for (genvar g = 0; g < csd_pkg::NCH; g++) begin : g_rd
      // counter read shows reload value until the first transfer loads it
      assign src_rd[g*csd_pkg::ADDR_W +: csd_pkg::ADDR_W] =
        (en_q[g] && sinc_q[g] && !first_q[g]) ? ptr_q[g] : src_q[g];
      assign dst_rd[g*csd_pkg::ADDR_W +: csd_pkg::ADDR_W] =
        (en_q[g] && dinc_q[g] && !first_q[g]) ? ptr_q[g] : dst_q[g];
      assign cnt_rd[g*csd_pkg::CNT_W +: csd_pkg::CNT_W] = first_q[g] ? rld_q[g] : cnt_q[g];
    end
  endgenerate

endmodule // csd_dma

/* File: sim/csd_mem.sv */
`timescale 1ns/1ns
// ------------------------------------------------
// shared bus memory seen from the transfer engine
// ------------------------------------------------
module csd_mem (
  // clock, reset and response delay
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  lat,
  // shared bus
  input  wire logic        bus_req,
  input  wire logic [19:0] bus_addr,
  output logic             bus_ack,
  output logic [15:0]      bus_rdata
);
  logic [3:0] wait_q, wait_d;
  logic       ack_d, flip_q;
  always_comb begin
    ack_d  = 1'h0;
    wait_d = 4'h0;
    if (bus_req && !bus_ack) begin
      ack_d  = (wait_q >= lat);
      wait_d = ack_d ? 4'h0 : wait_q + 4'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    bus_ack <= nrst & ack_d;
    wait_q  <= nrst ? wait_d : 4'h0;
    flip_q  <= nrst ? ~flip_q : 1'h0;
  end
  // outside the ack cycle the data lines toggle so stale data never looks valid
  assign bus_rdata = bus_ack ? (bus_addr[15:0] ^ 16'h5A3C) : {16{flip_q}};
endmodule // csd_mem

/* File: sim/csd_props.sv */
`timescale 1ns/1ns
// --------------------------
// port checker for csd_dma
// --------------------------
module csd_props (
  // clock and reset
  input wire logic                       sys_clk,
  input wire logic                       nrst,
  input wire logic                       clk_en,
  // configuration and requests
  input wire logic [csd_pkg::NCH-1:0]    cfg_wr_en,
  input wire logic [csd_pkg::NCH-1:0]    cfg_repeat,
  input wire logic [csd_pkg::NCH*4-1:0]  request_cause_select,
  input wire logic [csd_pkg::NCH-1:0]    soft_trig,
  // bus and status
  input wire logic                       bus_ack,
  input wire logic                       bus_req,
  input wire logic                       bus_rd,
  input wire logic                       bus_wr,
  input wire logic [csd_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [csd_pkg::DATA_W-1:0] bus_wdata,
  input wire logic [csd_pkg::NCH-1:0]    ch_enable,
  input wire logic [csd_pkg::NCH-1:0]    dma_irq
);
  logic [1:0] rep_q, rep_d;
  logic       in_reg;
  assign in_reg = bus_addr >= csd_pkg::REG_LO && bus_addr <= csd_pkg::REG_HI;
  // mode copy kept here because the design does not show it at its ports
  always_comb rep_d = (cfg_wr_en & cfg_repeat) | (~cfg_wr_en & rep_q);
  always_ff @(posedge sys_clk) rep_q <= nrst ? rep_d : 2'h0;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_reg_window: assert property (bus_req && in_reg |-> !bus_rd && !bus_wr)
    else $error("transfer touched the controller register window");
  a_rd_wr_apart: assert property (!(bus_rd && bus_wr))
    else $error("read and write strobes high together");
  a_addr_holds: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr))
    else $error("bus request or address dropped before ack");
  a_wdata_holds: assert property (bus_wr && !bus_ack |=> bus_wr && $stable(bus_wdata))
    else $error("write data changed before ack");
  a_read_then_write: assert property (bus_rd && bus_ack |=> bus_req)
    else $error("no write phase after read");
  a_soft_start: assert property (soft_trig[0] && ch_enable[0] && clk_en && !bus_req
    && request_cause_select[3:0] == csd_pkg::CAUSE_SOFT |-> ##[1:2] bus_req)
    else $error("software trigger did not start a transfer");
  a_irq_pulse: assert property (dma_irq[0] |=> !dma_irq[0])
    else $error("underflow interrupt longer than one cycle");
  a_irq_after_write: assert property (|dma_irq |-> $past(bus_ack) && $past(bus_req))
    else $error("underflow interrupt without a finished transfer");
  a_single_stop: assert property (dma_irq[0] && !rep_q[0] |-> ##[0:1] !ch_enable[0])
    else $error("single mode channel still enabled after underflow");
  a_repeat_stay: assert property (dma_irq[0] && rep_q[0] |=> ch_enable[0])
    else $error("repeat mode channel dropped after underflow");
  c_ch0_irq: cover property (dma_irq[0]);
  c_ch1_irq: cover property (dma_irq[1]);
  c_window: cover property (bus_req && in_reg);
endmodule // csd_props

bind csd_dma csd_props i_props (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
  .cfg_wr_en(cfg_wr_en), .cfg_repeat(cfg_repeat), .soft_trig(soft_trig),
  .request_cause_select(request_cause_select), .bus_ack(bus_ack), .bus_req(bus_req),
  .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .ch_enable(ch_enable), .dma_irq(dma_irq));

/* File: sim/tb.sv */
`timescale 1ns/1ns
module tb;
  typedef struct {
    int          ch, kind;
    logic        w, rp, si, di, en_after;
    logic [3:0]  cause;
    logic [19:0] s, d;
    logic [15:0] r;
  } csd_row_t;
  logic        sys_clk, nrst, clk_en, ext_irq_pin_zero, ext_irq_pin_one;
  logic        bus_ack, bus_req, bus_rd, bus_wr, bus_word;
  logic [1:0]  cfg_wr_en, cfg_en_val, cfg_word, cfg_repeat, cfg_src_inc, cfg_dst_inc;
  logic [1:0]  src_wr, dst_wr, rld_wr, soft_trig, ch_enable, dma_irq, cfg_error;
  logic [7:0]  request_cause_select;
  logic [19:0] wr_addr, bus_addr, st;
  logic [15:0] wr_cnt, periph_irq, bus_rdata, bus_wdata, ex;
  logic [39:0] src_rd, dst_rd;
  logic [31:0] cnt_rd;
  logic [3:0]  lat;
  int          n_mismatch, samples_checked;
  csd_row_t    r;
  // kind: 0 software, 1 pin zero fall, 2 peripheral, 3 pin one toggle
  csd_row_t    rows[5] = '{
    '{0, 0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 4'h1, 20'h10000, 20'h00400, 16'h0002},
    '{1, 2, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 4'h2, 20'h00500, 20'h20000, 16'h0001},
    '{0, 1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 4'h0, 20'h00600, 20'h00700, 16'h0001},
    '{1, 3, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 4'h7, 20'h30000, 20'h00800, 16'h0000},
    '{0, 0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 4'h1, 20'h00030, 20'h40000, 16'h0000}};
  csd_dma i_dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .cfg_wr_en(cfg_wr_en),
    .cfg_en_val(cfg_en_val), .cfg_word(cfg_word), .cfg_repeat(cfg_repeat),
    .cfg_src_inc(cfg_src_inc), .cfg_dst_inc(cfg_dst_inc), .src_wr(src_wr), .dst_wr(dst_wr),
    .request_cause_select(request_cause_select), .rld_wr(rld_wr), .wr_addr(wr_addr),
    .wr_cnt(wr_cnt), .soft_trig(soft_trig), .ext_irq_pin_zero(ext_irq_pin_zero),
    .ext_irq_pin_one(ext_irq_pin_one), .periph_irq(periph_irq), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .bus_req(bus_req), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_word(bus_word), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .ch_enable(ch_enable),
    .dma_irq(dma_irq), .cfg_error(cfg_error), .src_rd(src_rd), .dst_rd(dst_rd),
    .cnt_rd(cnt_rd));
  csd_mem i_mem (.sys_clk(sys_clk), .nrst(nrst), .lat(lat), .bus_req(bus_req),
    .bus_addr(bus_addr), .bus_ack(bus_ack), .bus_rdata(bus_rdata));
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [19:0] g, input logic [19:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask
  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask
  // bounded wait for a request, or for an ack and one edge past it
  task automatic wait_for(input bit ack);
    int n;
    n = 0;
    while ((ack ? bus_ack : bus_req) !== 1'h1 && n < 40) begin
      step;
      n++;
    end
    chk({19'h0, n == 40}, 20'h0, "bus handshake timeout");
    if (ack) step;
  endtask
  task automatic setup(input int ch, input logic w, rp, si, di, input logic [3:0] c,
                       input logic [19:0] s, d, input logic [15:0] rl);
    cfg_en_val[ch] = 1'h0;
    {cfg_word[ch], cfg_repeat[ch], cfg_src_inc[ch], cfg_dst_inc[ch]} = {w, rp, si, di};
    request_cause_select[ch*4+:4] = c;
    cfg_wr_en[ch] = 1'h1;
    step;
    {cfg_wr_en, wr_addr, src_wr[ch]} = {2'h0, s, 1'h1};
    step;
    {src_wr, wr_addr, dst_wr[ch]} = {2'h0, d, 1'h1};
    step;
    {dst_wr, wr_cnt, rld_wr[ch]} = {2'h0, rl, 1'h1};
    step;
    {rld_wr, cfg_en_val[ch], cfg_wr_en[ch]} = {2'h0, 2'h3};
    step;
    cfg_wr_en = 2'h0;
    step;
  endtask
  task automatic xfer(input int ch, kind, input logic [3:0] c, input logic [19:0] es, ed,
                      input logic w, ei);
    case (kind)
      0: soft_trig[ch] = 1'h1;
      1: ext_irq_pin_zero = 1'h0;
      2: periph_irq[c] = 1'h1;
      default: ext_irq_pin_one = ~ext_irq_pin_one;
    endcase
    step;
    {soft_trig, periph_irq, ext_irq_pin_zero} = {18'h0, 1'h1};
    wait_for(1'h0);
    ex = (es >= 20'h00020 && es <= 20'h0003F) ? 16'h0000 : es[15:0] ^ 16'h5A3C;
    chk(bus_addr, es, "source address");
    chk({19'h0, bus_rd}, {19'h0, !(es >= 20'h00020 && es <= 20'h0003F)}, "read strobe");
    chk({19'h0, bus_word}, {19'h0, w}, "unit size");
    wait_for(1'h1);
    chk(bus_addr, ed, "destination address");
    chk({19'h0, bus_wr}, {19'h0, !(ed >= 20'h00020 && ed <= 20'h0003F)}, "write strobe");
    chk({4'h0, bus_wdata & {{8{w}}, 8'hFF}}, {4'h0, ex & {{8{w}}, 8'hFF}}, "data");
    wait_for(1'h1);
    chk({19'h0, dma_irq[ch]}, {19'h0, ei}, "underflow interrupt");
  endtask
  initial begin
    #20000;
    n_mismatch++;
    end_sim;
  end
  initial begin
    {cfg_wr_en, cfg_en_val, cfg_word, cfg_repeat, cfg_src_inc, cfg_dst_inc} = 12'h000;
    {src_wr, dst_wr, rld_wr, soft_trig, request_cause_select, periph_irq} = 32'h0;
    {wr_addr, wr_cnt, lat} = 40'h0;
    {ext_irq_pin_zero, ext_irq_pin_one, clk_en, nrst} = 4'hA;
    repeat (2) @(posedge sys_clk);
    #1 nrst = 1'h1;
    chk({15'h0, bus_req, ch_enable, dma_irq}, 20'h0, "reset outputs");
    soft_trig = 2'h3;
    step;
    soft_trig = 2'h0;
    repeat (6) step;
    chk({19'h0, bus_req}, 20'h0, "request while disabled");
    foreach (rows[i]) begin
      r = rows[i];
      lat = 4'(i);
      setup(r.ch, r.w, r.rp, r.si, r.di, r.cause, r.s, r.d, r.r);
      for (int k = 0; k <= int'(r.r); k++) begin
        st = 20'(k * (r.w ? 2 : 1));
        xfer(r.ch, r.kind, r.cause, r.si ? r.s + st : r.s,
             (r.di && !r.si) ? r.d + st : r.d, r.w, k == int'(r.r));
      end
      repeat (2) step;
      chk({19'h0, ch_enable[r.ch]}, {19'h0, r.en_after}, "enable after underflow");
    end
    setup(0, 1'h0, 1'h1, 1'h1, 1'h0, 4'h1, 20'h01000, 20'h02000, 16'h0005);
    setup(1, 1'h0, 1'h1, 1'h1, 1'h0, 4'h1, 20'h03000, 20'h04000, 16'h0005);
    soft_trig = 2'h3;
    step;
    soft_trig = 2'h0;
    wait_for(1'h0);
    chk(bus_addr, 20'h01000, "channel zero first");
    wait_for(1'h1);
    wait_for(1'h1);
    wait_for(1'h0);
    chk(bus_addr, 20'h03000, "channel one second");
    wait_for(1'h1);
    wait_for(1'h1);
    {wr_addr, dst_wr} = {20'h05555, 2'h1};
    step;
    dst_wr = 2'h0;
    step;
    chk(dst_rd[19:0], 20'h02000, "fixed pointer write while enabled");
    chk(src_rd[19:0], 20'h01001, "working pointer read");
    chk({4'h0, cnt_rd[15:0]}, 20'h00004, "counter after one unit");
    chk({18'h0, cfg_error}, 20'h0, "configuration error flag");
    end_sim;
  end
endmodule // tb
